// ### wake_event_pkg.sv
// Constants and types shared by the wake event indicator block
package wake_event_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] PMC_ADDR       = 8'h84;
  localparam logic [7:0] INT_STS_ADDR   = 8'h90;
  localparam logic [7:0] INT_MASK_ADDR  = 8'h94;
  localparam logic [7:0] BYTE_TEST_ADDR = 8'h98;

  // ----------------------------------------------------------------
  // Field positions of power_management_control
  // ----------------------------------------------------------------
  localparam int READY_BIT  = 0;
  localparam int EN_BIT     = 1;
  localparam int POL_BIT    = 2;
  localparam int IND_BIT    = 3;
  localparam int CAUSE_LO   = 4;
  localparam int TYPE_BIT   = 6;
  localparam int ED_EN_BIT  = 8;
  localparam int WOL_EN_BIT = 9;
  localparam int MODE_LO    = 12;

  // Interrupt status and mask bits
  localparam int IRQ_WAKE_BIT  = 0;
  localparam int IRQ_READY_BIT = 1;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  CAUSE_NONE     = 2'h0;
  localparam logic [1:0]  MODE_FULL      = 2'h0;
  localparam logic [1:0]  MODE_RESERVED  = 2'h3;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;
  localparam logic [1:0]  INT_MASK_RESET = 2'h0;
  localparam logic [31:0] BYTE_TEST_READ = 32'h00000000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS        = 100;
  localparam int PULSE_MS      = 50;
  localparam int PULSE_CYCLES  = (PULSE_MS * 1000000) / CLK_NS;
  localparam int SETTLE_NS     = 2000;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_W      = 5;
  localparam int PULSE_W       = 20;

  typedef enum logic [1:0] {PS_FULL, PS_REDUCED, PS_SETTLE} power_state_t;

endpackage : wake_event_pkg

// ### pulse_timer.sv
// Fixed-width pulse timer for the power-event output
`timescale 1ns/1ps
module pulse_timer
  import wake_event_pkg::*;
#(
  parameter int CYCLES = PULSE_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic stop,
  output logic      busy
);

  typedef struct packed {
    logic               busy;
    logic [PULSE_W-1:0] count;
  } timer_state_t;

  timer_state_t cur;
  timer_state_t next_cur;

  // ----------------------------------------------------------------
  // Countdown
  // ----------------------------------------------------------------
  // Restart on every start; stop ends the pulse at once
  always_comb begin
    next_cur = cur;
    if (start) begin
      next_cur.busy  = 1'b1;                           // see [R18]
      next_cur.count = PULSE_W'(CYCLES - 1);           // see [R18]
    end else if (stop) begin
      next_cur.busy  = 1'b0;
      next_cur.count = '0;
    end else if (cur.busy) begin
      if (cur.count == '0) begin
        next_cur.busy = 1'b0;                          // see [R5]
      end else begin
        next_cur.count = cur.count - PULSE_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign busy = cur.busy;

  // Pulse never outlives its length
  chk_pulse_bound: assert property (@(posedge clk) disable iff (!rst_n)
    cur.busy |-> cur.count < PULSE_W'(CYCLES)) // see [R5]
    else $error("pulse counter beyond length");

endmodule : pulse_timer

// ### wake_event_indicator.sv
// Wake event cause, power-event output and ready flag with AXI4-Lite access
//
// Operation
// [R1] Cause field: 00 none, 01 energy, 10 wake frame, 11 both.
// [R2] Cause bits clear only by writing one; zero leaves them.
// [R3] Cause bits clear only once back at full power with ready set.
// [R4] A cause bit stays set while its event source is still active.
// [R5] Pulse mode drives the power-event output for 50 ms per event.
// [R6] Static mode holds the power-event output from detection onward.
// [R7] Clearing cause bits or the event enable releases the output.
// [R8] Push-pull output: polarity bit one is active high, zero low.
// [R9] Open-drain output ignores polarity and is always active low.
// [R10] Output enable gates the pin only, never the internal interrupt.
// [R11] Ready reads one only after stabilising at full power.
// [R12] The control register stays readable in every power state.
// [R13] Host accesses no other register while ready is zero.
// [R14] While not ready, host reads only config and control registers.
// [R15] Power state select: 00 full, 01 wake detect, 10 energy; 11 reserved.
// [R16] Drive type bit: zero open-drain, one push-pull.
// [R17] Any write to byte test register wakes a reduced-power device.
// [R18] Pulse width is counted on the device clock, restarting per event.
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module wake_event_indicator
  import wake_event_pkg::*;
#(
  parameter int PULSE_LEN = PULSE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        energySource,
  input  wire logic        wakeFrameSource,
  output logic             pmeOut,
  output logic             pmeOe,
  output logic             irq
);

  typedef struct packed {
    logic         awReady;
    logic         wReady;
    logic         awHeld;
    logic         wHeld;
    logic [7:0]   awAddr;
    logic [31:0]  wData;
    logic [3:0]   wStrb;
    logic         bValid;
    logic [1:0]   bResp;
    logic         arReady;
    logic         rValid;
    logic [1:0]   rResp;
    logic [31:0]  rData;
    logic [1:0]   srcMeta;
    logic [1:0]   srcSync;
    logic [1:0]   srcPrev;
    logic [1:0]   mode;
    logic         wolEn;
    logic         edEn;
    logic         driveType;
    logic [1:0]   cause;
    logic         pulseMode;
    logic         polarity;
    logic         outEn;
    logic         ready;
    power_state_t pwr;
    logic [SETTLE_W-1:0] settle;
    logic         staticHold;
    logic         pmeOut;
    logic         pmeOe;
    logic [1:0]   intSts;
    logic [1:0]   intMask;
    logic         irq;
  } wake_state_t;

  wake_state_t cur;
  wake_state_t next_cur;

  logic        timerBusy;
  logic        timerStart;
  logic        timerStop;
  logic [1:0]  detect;
  logic [1:0]  enables;
  logic        allowed;
  logic        active;
  logic [31:0] pmcRead;
  logic [31:0] wMask;
  logic [31:0] wBits;
  logic [1:0]  causeClr;
  logic [1:0]  stsClr;

  // ----------------------------------------------------------------
  // Pulse timer
  // ----------------------------------------------------------------
  pulse_timer #(
    .CYCLES (PULSE_LEN)
  ) u_pulse (
    .clk   (clk),
    .rst_n (rst_n),
    .start (timerStart),
    .stop  (timerStop),
    .busy  (timerBusy)
  );

  // ----------------------------------------------------------------
  // Event detection and output qualification
  // ----------------------------------------------------------------
  // Bit 0 energy, bit 1 wake frame; edges of enabled synced sources
  always_comb begin
    enables    = {cur.wolEn, cur.edEn};
    detect     = cur.srcSync & ~cur.srcPrev & enables;
    allowed    = |(cur.cause & enables);                    // see [R7]
    active     = cur.pulseMode ? timerBusy : cur.staticHold; // see [R5] see [R6]
    timerStart = (|detect) & cur.pulseMode;                  // see [R18]
    timerStop  = ~allowed & ~(|detect);                      // see [R7]
    pmcRead    = '0;
    pmcRead[MODE_LO +: 2]    = cur.mode;
    pmcRead[WOL_EN_BIT]      = cur.wolEn;
    pmcRead[ED_EN_BIT]       = cur.edEn;
    pmcRead[TYPE_BIT]        = cur.driveType;
    pmcRead[CAUSE_LO +: 2]   = cur.cause;                    // see [R1]
    pmcRead[IND_BIT]         = cur.pulseMode;
    pmcRead[POL_BIT]         = cur.polarity;
    pmcRead[EN_BIT]          = cur.outEn;
    pmcRead[READY_BIT]       = cur.ready;                    // see [R11]
    wMask = {{8{cur.wStrb[3]}}, {8{cur.wStrb[2]}},
             {8{cur.wStrb[1]}}, {8{cur.wStrb[0]}}};
    wBits = cur.wData & wMask;
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Bus slave, registers, power state and output pin
  always_comb begin
    next_cur = cur;
    causeClr = '0;
    stsClr   = '0;
    // Source synchronisers and edge history
    next_cur.srcMeta = {wakeFrameSource, energySource};
    next_cur.srcSync = cur.srcMeta;
    next_cur.srcPrev = cur.srcSync;

    // Write address and data are taken in either order
    if (awvalid && cur.awReady) begin
      next_cur.awHeld  = 1'b1;
      next_cur.awAddr  = awaddr;
      next_cur.awReady = 1'b0;
    end
    if (wvalid && cur.wReady) begin
      next_cur.wHeld  = 1'b1;
      next_cur.wData  = wdata;
      next_cur.wStrb  = wstrb;
      next_cur.wReady = 1'b0;
    end
    if (cur.bValid && bready) begin
      next_cur.bValid  = 1'b0;
      next_cur.awReady = 1'b1;
      next_cur.wReady  = 1'b1;
    end

    // Perform a write once both halves are in
    if (cur.awHeld && cur.wHeld && !cur.bValid) begin
      next_cur.awHeld = 1'b0;
      next_cur.wHeld  = 1'b0;
      next_cur.bValid = 1'b1;
      next_cur.bResp  = RESP_OKAY;
      if (cur.awAddr == BYTE_TEST_ADDR) begin
        if (cur.pwr == PS_REDUCED) begin
          next_cur.pwr    = PS_SETTLE;                       // see [R17]
          next_cur.settle = SETTLE_W'(SETTLE_CYCLES - 1);
        end
      end else if (cur.awAddr != PMC_ADDR && cur.awAddr != INT_STS_ADDR &&
                   cur.awAddr != INT_MASK_ADDR) begin
        next_cur.bResp = RESP_DECERR;
      end else if (!cur.ready) begin
        next_cur.bResp = RESP_SLVERR;                        // see [R13] see [R17]
      end else if (cur.awAddr == PMC_ADDR) begin
        if (cur.wStrb[1]) begin
          next_cur.wolEn = cur.wData[WOL_EN_BIT];
          next_cur.edEn  = cur.wData[ED_EN_BIT];
          if (cur.wData[MODE_LO +: 2] != MODE_FULL &&
              cur.wData[MODE_LO +: 2] != MODE_RESERVED) begin
            next_cur.mode  = cur.wData[MODE_LO +: 2];        // see [R15]
            next_cur.pwr   = PS_REDUCED;
            next_cur.ready = 1'b0;                           // see [R11]
          end
        end
        if (cur.wStrb[0]) begin
          next_cur.driveType = cur.wData[TYPE_BIT];          // see [R16]
          next_cur.pulseMode = cur.wData[IND_BIT];
          next_cur.polarity  = cur.wData[POL_BIT];
          next_cur.outEn     = cur.wData[EN_BIT];
          // One clears, zero keeps, live source blocks
          causeClr = wBits[CAUSE_LO +: 2] & ~cur.srcSync;    // see [R2] see [R3] see [R4]
        end
      end else if (cur.awAddr == INT_STS_ADDR) begin
        stsClr = wBits[1:0];
      end else begin
        next_cur.intMask = wBits[1:0];
      end
    end

    // Reads: control register in any state, others only when ready
    if (cur.rValid && rready) begin
      next_cur.rValid  = 1'b0;
      next_cur.arReady = 1'b1;
    end
    if (arvalid && cur.arReady) begin
      next_cur.arReady = 1'b0;
      next_cur.rValid  = 1'b1;
      next_cur.rResp   = RESP_OKAY;
      next_cur.rData   = '0;
      if (araddr == PMC_ADDR) begin
        next_cur.rData = pmcRead;                            // see [R12]
      end else if (araddr != INT_STS_ADDR && araddr != INT_MASK_ADDR &&
                   araddr != BYTE_TEST_ADDR) begin
        next_cur.rResp = RESP_DECERR;
      end else if (!cur.ready) begin
        next_cur.rResp = RESP_SLVERR;                        // see [R14]
      end else if (araddr == INT_STS_ADDR) begin
        next_cur.rData[1:0] = cur.intSts;
      end else if (araddr == INT_MASK_ADDR) begin
        next_cur.rData[1:0] = cur.intMask;
      end else begin
        next_cur.rData = BYTE_TEST_READ;
      end
    end

    // Cause field: detection wins over a clear in the same cycle
    next_cur.cause = (cur.cause & ~causeClr) | detect;       // see [R1] see [R2]
    next_cur.staticHold = (|detect) | (cur.staticHold & allowed &
                          (|next_cur.cause));                // see [R6] see [R7]

    // Power state sequencing
    case (cur.pwr)
      PS_FULL: begin
        next_cur.mode = next_cur.mode;
      end
      PS_REDUCED: begin
        if (|detect) begin
          next_cur.pwr    = PS_SETTLE;
          next_cur.settle = SETTLE_W'(SETTLE_CYCLES - 1);
        end
      end
      PS_SETTLE: begin
        if (cur.settle == '0) begin
          next_cur.pwr   = PS_FULL;
          next_cur.mode  = MODE_FULL;
          next_cur.ready = 1'b1;                             // see [R11]
        end else begin
          next_cur.settle = cur.settle - SETTLE_W'(1);
        end
      end
      default: begin
        next_cur.pwr = PS_SETTLE;
      end
    endcase

    // Sticky interrupt status; set wins over write-one clear
    next_cur.intSts = cur.intSts & ~stsClr;
    if (|detect) begin
      next_cur.intSts[IRQ_WAKE_BIT] = 1'b1;                  // see [R10]
    end
    if (next_cur.ready && !cur.ready) begin
      next_cur.intSts[IRQ_READY_BIT] = 1'b1;
    end
    next_cur.irq = |(next_cur.intSts & next_cur.intMask);

    // Pin drive: open-drain pulls low, push-pull follows polarity
    next_cur.pmeOut = cur.driveType & (cur.polarity ? active : ~active); // see [R8] see [R9]
    next_cur.pmeOe  = cur.outEn & (cur.driveType | active);  // see [R10] see [R16]
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur          <= '0;
      cur.awReady  <= 1'b1;
      cur.wReady   <= 1'b1;
      cur.arReady  <= 1'b1;
      cur.pwr      <= PS_SETTLE;
      cur.settle   <= SETTLE_W'(SETTLE_CYCLES - 1);
      cur.intMask  <= INT_MASK_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state register
  assign awready = cur.awReady;
  assign wready  = cur.wReady;
  assign bvalid  = cur.bValid;
  assign bresp   = cur.bResp;
  assign arready = cur.arReady;
  assign rvalid  = cur.rValid;
  assign rresp   = cur.rResp;
  assign rdata   = cur.rData;
  assign pmeOut  = cur.pmeOut;
  assign pmeOe   = cur.pmeOe;
  assign irq     = cur.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_cause_set: assert property (@(posedge clk) disable iff (!rst_n)
    detect[0] |=> cur.cause[0]) // see [R1]
    else $error("energy event did not set cause");

  chk_zero_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(cur.cause[1]) |-> $past(causeClr[1])) // see [R2]
    else $error("cause bit cleared without a one write");

  chk_clear_ready: assert property (@(posedge clk) disable iff (!rst_n)
    (|causeClr) |-> cur.ready && cur.pwr == PS_FULL) // see [R3]
    else $error("cause cleared while not ready");

  chk_source_holds: assert property (@(posedge clk) disable iff (!rst_n)
    cur.cause[0] && cur.srcSync[0] |=> cur.cause[0]) // see [R4]
    else $error("cause dropped with live source");

  chk_static_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !cur.pulseMode && (|detect) ##1 !cur.pulseMode && allowed |=> active) // see [R6]
    else $error("static indication not held");

  chk_release_cause: assert property (@(posedge clk) disable iff (!rst_n)
    cur.cause == CAUSE_NONE && !(|detect) |=> !cur.staticHold) // see [R7]
    else $error("output still active with no cause");

  chk_open_drain: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(cur.driveType) |-> !cur.pmeOut) // see [R9]
    else $error("open-drain output driven high");

  chk_polarity: assert property (@(posedge clk) disable iff (!rst_n)
    $past(cur.driveType) && $past(cur.outEn) |->
      cur.pmeOut == ($past(cur.polarity) ~^ $past(active))) // see [R8]
    else $error("push-pull level does not follow polarity");

  chk_irq_ungated: assert property (@(posedge clk) disable iff (!rst_n)
    (|detect) && !cur.outEn |=> cur.intSts[IRQ_WAKE_BIT]) // see [R10]
    else $error("interrupt gated by output enable");

  chk_ready_full: assert property (@(posedge clk) disable iff (!rst_n)
    cur.ready |-> cur.pwr == PS_FULL && cur.mode == MODE_FULL) // see [R11]
    else $error("ready set outside full power");

  chk_wake_write: assert property (@(posedge clk) disable iff (!rst_n)
    cur.pwr == PS_REDUCED && cur.awHeld && cur.wHeld && !cur.bValid &&
    cur.awAddr == BYTE_TEST_ADDR |=> ##[20:21] cur.ready) // see [R17]
    else $error("byte test write did not wake device");

endmodule : wake_event_indicator

// ### axi_host_model.sv
// AXI4-Lite host model that drives the register bus of the wake event block
`timescale 1ns/1ps
module axi_host_model (
  input  wire logic        clk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  logic hung;

  // Idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, hung} = '0;
  end

  // ----------------------------------------------------------------
  // Write: address and data offered together, released when taken
  // ----------------------------------------------------------------
  task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    r = 2'h0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done && n < 100) begin
      @(posedge clk);
      n++;
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;          // Released address no longer shows the old value
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    hung = !done;
  endtask : write

  // ----------------------------------------------------------------
  // Read: address held until taken, data taken with rvalid
  // ----------------------------------------------------------------
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    {d, r} = '0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done && n < 100) begin
      @(posedge clk);
      n++;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    hung = !done;
  endtask : read
endmodule : axi_host_model

// ### wake_event_indicator_tb_top.sv
// Self-checking bench for the wake event indicator block
`timescale 1ns/1ps
module wake_event_indicator_tb_top;
  import wake_event_pkg::*;
  localparam int          PULSE = 16;
  localparam logic [31:0] ED = 32'h1 << ED_EN_BIT;
  localparam logic [31:0] WL = 32'h1 << WOL_EN_BIT;
  localparam logic [31:0] PP = 32'h1 << TYPE_BIT;
  localparam logic [31:0] PL = 32'h1 << POL_BIT;
  localparam logic [31:0] EN = 32'h1 << EN_BIT;
  localparam logic [31:0] IN = 32'h1 << IND_BIT;
  localparam logic [31:0] RD = 32'h1 << READY_BIT;
  localparam logic [31:0] C0 = 32'h1 << CAUSE_LO;
  localparam logic [31:0] C1 = 32'h2 << CAUSE_LO;
  localparam logic [31:0] D1 = 32'h1 << MODE_LO;
  localparam logic [31:0] CF = ED | WL | PP | PL | EN;
  localparam logic [31:0] PC = WL | PP | PL | EN | IN;

  logic        clk = 1'b0;
  logic        rst_n;
  logic        energySource;
  logic        wakeFrameSource;
  logic        pmeOut;
  logic        pmeOe;
  logic        irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          errors;
  int          testsRun;
  int          n;

  always #50 clk = ~clk;

  wake_event_indicator #(.PULSE_LEN(PULSE)) u_wake_event_indicator (
    .clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .energySource(energySource), .wakeFrameSource(wakeFrameSource), .pmeOut(pmeOut),
    .pmeOe(pmeOe), .irq(irq));

  axi_host_model u_host (
    .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ----------------------------------------------------------------
  // Compare and access helpers
  // ----------------------------------------------------------------
  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkWord

  task automatic chkBit(input logic got, input logic exp);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask : chkBit

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick

  // Bus write, response compared, then pins given time to follow
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    u_host.write(a, d, r);
    if (u_host.hung) begin
      errors++;
      print_verdict();
    end
    chkWord({30'h0, r}, {30'h0, e});
    tick(2);
  endtask : wr

  // Bus read; data compared only when an OKAY answer is expected
  task automatic rd(input logic [7:0] a, input logic [1:0] e, input logic [31:0] x);
    logic [31:0] d;
    logic [1:0]  r;
    u_host.read(a, d, r);
    if (u_host.hung) begin
      errors++;
      print_verdict();
    end
    chkWord({30'h0, r}, {30'h0, e});
    if (e === RESP_OKAY) chkWord(d, x);
  endtask : rd

  task automatic print_verdict();
    if (errors == 0 && testsRun > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {errors, testsRun} = '0;
    rst_n = 1'b0;
    energySource = 1'b0;
    wakeFrameSource = 1'b0;
    tick(20);
    rst_n <= 1'b1;
    rd(PMC_ADDR, RESP_OKAY, 32'h0);
    rd(INT_STS_ADDR, RESP_SLVERR, 32'h0);
    wr(INT_MASK_ADDR, 32'h1, RESP_SLVERR);
    rd(8'h00, RESP_DECERR, 32'h0);
    tick(25);
    rd(PMC_ADDR, RESP_OKAY, RD);
    rd(INT_STS_ADDR, RESP_OKAY, 32'h2);
    wr(INT_STS_ADDR, 32'h2, RESP_OKAY);
    rd(INT_STS_ADDR, RESP_OKAY, 32'h0);
    wr(INT_MASK_ADDR, 32'h1, RESP_OKAY);
    rd(INT_MASK_ADDR, RESP_OKAY, 32'h1);
    // Static push-pull, active high
    wr(PMC_ADDR, CF, RESP_OKAY);
    chkBit(pmeOe, 1'b1);
    chkBit(pmeOut, 1'b0);
    energySource <= 1'b1;
    tick(8);
    rd(PMC_ADDR, RESP_OKAY, CF | C0 | RD);
    chkBit(pmeOut, 1'b1);
    chkBit(irq, 1'b1);
    wr(PMC_ADDR, CF | C0, RESP_OKAY);
    rd(PMC_ADDR, RESP_OKAY, CF | C0 | RD);
    energySource <= 1'b0;
    tick(5);
    wr(PMC_ADDR, CF, RESP_OKAY);
    rd(PMC_ADDR, RESP_OKAY, CF | C0 | RD);
    chkBit(pmeOut, 1'b1);
    wr(PMC_ADDR, CF | C0, RESP_OKAY);
    rd(PMC_ADDR, RESP_OKAY, CF | RD);
    chkBit(pmeOut, 1'b0);
    wr(INT_STS_ADDR, 32'h1, RESP_OKAY);
    chkBit(irq, 1'b0);
    // Both sources at once
    energySource <= 1'b1;
    wakeFrameSource <= 1'b1;
    tick(8);
    energySource <= 1'b0;
    wakeFrameSource <= 1'b0;
    tick(5);
    rd(PMC_ADDR, RESP_OKAY, CF | C0 | C1 | RD);
    wr(PMC_ADDR, CF & ~PL, RESP_OKAY);
    chkBit(pmeOut, 1'b0);
    chkBit(pmeOe, 1'b1);
    wr(PMC_ADDR, ED | WL | PL | EN, RESP_OKAY);
    chkBit(pmeOe, 1'b1);
    chkBit(pmeOut, 1'b0);
    wr(PMC_ADDR, PP | PL | EN, RESP_OKAY);
    chkBit(pmeOut, 1'b0);
    wr(PMC_ADDR, PP | PL | EN | C0 | C1, RESP_OKAY);
    wr(INT_STS_ADDR, 32'h1, RESP_OKAY);
    // Pin disabled, interrupt still raised
    wr(PMC_ADDR, WL | PP | PL, RESP_OKAY);
    wakeFrameSource <= 1'b1;
    tick(8);
    wakeFrameSource <= 1'b0;
    chkBit(irq, 1'b1);
    chkBit(pmeOe, 1'b0);
    wr(PMC_ADDR, WL | PP | PL | C1, RESP_OKAY);
    wr(INT_STS_ADDR, 32'h1, RESP_OKAY);
    // Pulse mode width
    wr(PMC_ADDR, PC, RESP_OKAY);
    wakeFrameSource <= 1'b1;
    n = 0;
    while (pmeOut !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    n = 0;
    while (pmeOut === 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    wakeFrameSource <= 1'b0;
    chkWord(n, PULSE);
    rd(PMC_ADDR, RESP_OKAY, PC | C1 | RD);
    // Reduced power, clear refused, wake by byte test write
    wr(PMC_ADDR, PC | D1, RESP_OKAY);
    rd(PMC_ADDR, RESP_OKAY, PC | C1 | D1);
    wr(PMC_ADDR, PC | C1, RESP_SLVERR);
    wr(BYTE_TEST_ADDR, 32'h0, RESP_OKAY);
    tick(25);
    rd(PMC_ADDR, RESP_OKAY, PC | C1 | RD);
    wr(PMC_ADDR, PC | C1, RESP_OKAY);
    rd(PMC_ADDR, RESP_OKAY, PC | RD);
    // Energy-detect state, woken by an energy event
    wr(PMC_ADDR, CF | (32'h2 << MODE_LO), RESP_OKAY);
    rd(PMC_ADDR, RESP_OKAY, CF | (32'h2 << MODE_LO));
    energySource <= 1'b1;
    tick(30);
    energySource <= 1'b0;
    tick(5);
    rd(PMC_ADDR, RESP_OKAY, CF | C0 | RD);
    print_verdict();
  end
endmodule : wake_event_indicator_tb_top
